// file: src/fifo_port_ctrl.v
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "fifo_ctl_map.vh"
module fifo_port_ctrl #(
  parameter DW    = 18,
  parameter AW    = 12,
  parameter DEPTH = 4096
) (
  input  wire          CLK_I,
  input  wire          RST_I,
  input  wire          PSEL_I,
  input  wire          PENABLE_I,
  input  wire          PWRITE_I,
  input  wire [7:0]    PADDR_I,
  input  wire [31:0]   PWDATA_I,
  output reg  [31:0]   PRDATA_O,
  output reg           PREADY_O,
  output reg           PSLVERR_O,
  input  wire          MASTER_RESET_N_I,
  input  wire          WRITE_EN_N_I,
  input  wire [DW-1:0] WRITE_DATA_BUS_I,
  input  wire          READ_EN_N_I,
  output reg  [DW-1:0] READ_DATA_BUS_O,
  input  wire          FIRST_LOAD_N_I,
  input  wire          READ_CHAIN_IN_N_I,
  input  wire          WRITE_CHAIN_IN_N_I,
  output reg           EMPTY_FLAG_N_O,
  output reg           FULL_FLAG_N_O,
  output reg           ALMOST_EMPTY_N_O,
  output reg           ALMOST_FULL_N_O,
  output reg           HALF_FULL_N_O,
  output reg           READ_CHAIN_OUT_N_O,
  output reg           IRQ_O
);

  localparam [AW:0]   DEPTH_P = DEPTH[AW:0];
  localparam [AW:0]   HALF_P  = DEPTH_P >> 1;
  localparam [AW-1:0] LAST_P  = DEPTH_P[AW-1:0] - {{(AW-1){1'b0}}, 1'b1};

  function [AW:0] bin2gray;
    input [AW:0] b;
    begin
      bin2gray = b ^ (b >> 1);
    end
  endfunction

  function [AW:0] gray2bin;
    input [AW:0] g;
    integer      i;
    begin
      gray2bin[AW] = g[AW];
      for (i = AW - 1; i >= 0; i = i - 1) begin
        gray2bin[i] = gray2bin[i + 1] ^ g[i];
      end
    end
  endfunction

  // Both reset sources act on the clock edge
  wire fifo_rst = RST_I | ~MASTER_RESET_N_I;

  reg  [2:0]         mode_strap;
  reg                depth_force;
  reg  [`OFF_W-1:0]  ae_off;
  reg  [`OFF_W-1:0]  af_off;
  reg  [`IRQ_W-1:0]  int_stat;
  reg  [`IRQ_W-1:0]  int_mask;
  reg  [AW:0]        wptr;
  reg  [AW:0]        rptr;
  reg  [AW:0]        wgray;
  reg  [AW:0]        rgray;
  reg                wtok;
  reg                rtok;
  reg                pending;
  reg                out_valid;
  wire [AW:0]        wgray_rd;
  wire [AW:0]        rgray_wr;
  wire [DW-1:0]      ram_q;

  // Strap decode: {first-load, write-chain-in, read-chain-in}
  wire depth_mode = mode_strap[2] | depth_force;
  wire fallthrough_mode       = ~depth_mode & mode_strap[1];
  wire sync_flags = mode_strap[0];

  wire [AW:0] wptr_rd = gray2bin(wgray_rd);
  wire [AW:0] rptr_wr = gray2bin(rgray_wr);

  wire full_int  = (wptr[AW] != rptr_wr[AW]) && (wptr[AW-1:0] == rptr_wr[AW-1:0]);
  wire empty_int = (rptr == wptr_rd);

  wire [AW:0] wcount = wptr - rptr_wr;
  wire [AW:0] rcount = wptr_rd - rptr;
  wire [AW:0] dcount = wptr - rptr;

  // Write side
  wire wr_req  = ~WRITE_EN_N_I & wtok;
  wire wr_ok   = wr_req & ~full_int & FULL_FLAG_N_O;
  wire wr_last = (wptr[AW-1:0] == LAST_P);
  wire [AW:0] next_wptr = wr_ok ? wptr + {{AW{1'b0}}, 1'b1} : wptr;

  // Read side
  wire rd_req    = ~READ_EN_N_I & rtok;
  wire fetch_std = rd_req & ~empty_int & EMPTY_FLAG_N_O;
  wire consume   = out_valid & ~READ_EN_N_I;
  wire fetch_ft  = rtok & ~empty_int & ~pending & (~out_valid | consume);
  wire fetch     = fallthrough_mode ? fetch_ft : fetch_std;
  wire rd_last   = (rptr[AW-1:0] == LAST_P);
  wire [AW:0] next_rptr = fetch ? rptr + {{AW{1'b0}}, 1'b1} : rptr;

  wire next_out_valid = pending | (out_valid & ~consume);

  // Flag values one edge ahead so the pins stay registered
  wire [AW:0] cnt_r = sync_flags ? rcount : dcount;
  wire [AW:0] cnt_w = sync_flags ? wcount : dcount;
  wire next_ef = fallthrough_mode ? next_out_valid : ~empty_int;
  wire next_ff = ~full_int;
  wire next_ae = ~(cnt_r <= {1'b0, ae_off});
  wire next_af = ~(cnt_w >= (DEPTH_P - {1'b0, af_off}));
  wire next_hf = ~(wcount > HALF_P);

  wire wr_rej = wr_req & ~wr_ok;
  wire rd_rej = fallthrough_mode ? (~READ_EN_N_I & ~out_valid) : (rd_req & ~fetch_std);
  wire [`IRQ_W-1:0] events;
  assign events[`IRQ_WR_REJ] = wr_rej;
  assign events[`IRQ_RD_REJ] = rd_rej;
  assign events[`IRQ_FULL]   = ~next_ff & FULL_FLAG_N_O;
  assign events[`IRQ_EMPTY]  = ~next_ef & EMPTY_FLAG_N_O;

  fifo_store #(
    .DW (DW),
    .AW (AW)
  ) u_store (
    .clk_i     (CLK_I),
    .wr_en_i   (wr_ok),
    .wr_addr_i (wptr[AW-1:0]),
    .wr_data_i (WRITE_DATA_BUS_I),
    .rd_en_i   (fetch),
    .rd_addr_i (rptr[AW-1:0]),
    .rd_data_o (ram_q)
  );

  gray_sync #(
    .W (AW + 1)
  ) u_wsync (
    .clk_i (CLK_I),
    .rst_i (fifo_rst),
    .d_i   (wgray),
    .q_o   (wgray_rd)
  );

  gray_sync #(
    .W (AW + 1)
  ) u_rsync (
    .clk_i (CLK_I),
    .rst_i (fifo_rst),
    .d_i   (rgray),
    .q_o   (rgray_wr)
  );

  // Pointers, tokens and mode capture
  always @(posedge CLK_I) begin
    if (fifo_rst) begin
      wptr       <= {(AW+1){1'b0}};
      rptr       <= {(AW+1){1'b0}};
      wgray      <= {(AW+1){1'b0}};
      rgray      <= {(AW+1){1'b0}};
      mode_strap <= {FIRST_LOAD_N_I, WRITE_CHAIN_IN_N_I, READ_CHAIN_IN_N_I};
      wtok       <= ~FIRST_LOAD_N_I;
      rtok       <= ~FIRST_LOAD_N_I;
    end else begin
      wptr  <= next_wptr;
      rptr  <= next_rptr;
      wgray <= bin2gray(next_wptr);
      rgray <= bin2gray(next_rptr);
      if (!depth_mode) begin
        wtok <= 1'b1;
      end else if (wr_ok && wr_last) begin
        wtok <= 1'b0;
      end else if (!WRITE_CHAIN_IN_N_I) begin
        wtok <= 1'b1;
      end
      if (!depth_mode) begin
        rtok <= 1'b1;
      end else if (fetch && rd_last) begin
        rtok <= 1'b0;
      end else if (!READ_CHAIN_IN_N_I) begin
        rtok <= 1'b1;
      end
    end
  end

  // Output word pipeline
  always @(posedge CLK_I) begin
    if (fifo_rst) begin
      pending         <= 1'b0;
      out_valid       <= 1'b0;
      READ_DATA_BUS_O <= {DW{1'b0}};
    end else begin
      pending   <= fetch;
      out_valid <= next_out_valid;
      if (pending) begin
        READ_DATA_BUS_O <= ram_q;
      end
    end
  end

  // Flag and chain pins
  always @(posedge CLK_I) begin
    if (fifo_rst) begin
      EMPTY_FLAG_N_O     <= 1'b0;
      FULL_FLAG_N_O      <= 1'b1;
      ALMOST_EMPTY_N_O   <= 1'b0;
      ALMOST_FULL_N_O    <= 1'b1;
      HALF_FULL_N_O      <= 1'b1;
      READ_CHAIN_OUT_N_O <= 1'b1;
    end else begin
      EMPTY_FLAG_N_O   <= next_ef;
      FULL_FLAG_N_O    <= next_ff;
      ALMOST_EMPTY_N_O <= next_ae;
      ALMOST_FULL_N_O  <= next_af;
      if (depth_mode) begin
        HALF_FULL_N_O      <= ~(wr_ok & wr_last);
        READ_CHAIN_OUT_N_O <= ~(fetch & rd_last);
      end else begin
        HALF_FULL_N_O      <= next_hf;
        READ_CHAIN_OUT_N_O <= 1'b1;
      end
    end
  end

  // APB slave: answers in the second access cycle
  wire       access   = PSEL_I & PENABLE_I;
  wire       complete = access & PREADY_O;
  wire       wr_cmp   = complete & PWRITE_I;
  wire [7:0] addr     = PADDR_I;
  reg        mapped;
  reg [31:0] rd_word;

  always @* begin
    mapped  = 1'b1;
    rd_word = 32'h0000_0000;
    case (addr)
      `OFS_CTRL: begin
        rd_word[`CTRL_DEPTH_BIT] = depth_force;
      end
      `OFS_OFFSET: begin
        rd_word[`OFF_AE_LSB +: `OFF_W] = ae_off;
        rd_word[`OFF_AF_LSB +: `OFF_W] = af_off;
      end
      `OFS_STATUS: begin
        rd_word[AW:0]                 = dcount;
        rd_word[`STAT_EMPTY_BIT]      = EMPTY_FLAG_N_O;
        rd_word[`STAT_FULL_BIT]       = FULL_FLAG_N_O;
        rd_word[`STAT_AE_BIT]         = ALMOST_EMPTY_N_O;
        rd_word[`STAT_AF_BIT]         = ALMOST_FULL_N_O;
        rd_word[`STAT_HF_BIT]         = HALF_FULL_N_O;
        rd_word[`STAT_MODE_LSB +: 3]  = mode_strap;
        rd_word[`STAT_DEPTH_BIT]      = depth_mode;
        rd_word[`STAT_WTOK_BIT]       = wtok;
        rd_word[`STAT_RTOK_BIT]       = rtok;
      end
      `OFS_INT_STAT: begin
        rd_word[`IRQ_W-1:0] = int_stat;
      end
      `OFS_INT_MASK: begin
        rd_word[`IRQ_W-1:0] = int_mask;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always @(posedge CLK_I) begin
    if (RST_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
    end else begin
      PREADY_O  <= access & ~PREADY_O;
      PSLVERR_O <= access & ~PREADY_O & ~mapped;
      if (access && !PREADY_O && !PWRITE_I) begin
        PRDATA_O <= rd_word;
      end
    end
  end

  // Software registers; status bits: set wins over write-one clear
  always @(posedge CLK_I) begin
    if (RST_I) begin
      depth_force <= 1'b0;
      ae_off      <= `OFFSET_RST;
      af_off      <= `OFFSET_RST;
      int_stat    <= {`IRQ_W{1'b0}};
      int_mask    <= {`IRQ_W{1'b0}};
      IRQ_O       <= 1'b0;
    end else begin
      if (wr_cmp && addr == `OFS_CTRL) begin
        depth_force <= PWDATA_I[`CTRL_DEPTH_BIT];
      end
      if (wr_cmp && addr == `OFS_OFFSET) begin
        ae_off <= PWDATA_I[`OFF_AE_LSB +: `OFF_W];
        af_off <= PWDATA_I[`OFF_AF_LSB +: `OFF_W];
      end
      if (wr_cmp && addr == `OFS_INT_MASK) begin
        int_mask <= PWDATA_I[`IRQ_W-1:0];
      end
      if (wr_cmp && addr == `OFS_INT_STAT) begin
        int_stat <= (int_stat & ~PWDATA_I[`IRQ_W-1:0]) | (events & {`IRQ_W{~fifo_rst}});
      end else begin
        int_stat <= int_stat | (events & {`IRQ_W{~fifo_rst}});
      end
      IRQ_O <= |(int_stat & int_mask);
    end
  end

endmodule

// file: src/fifo_ctl_map.vh
// Contract
// - Write data and read data buses are both 18 bits wide.
// - Read strobe low at a clock edge moves the next stored word out.
// - Read strobe high keeps the output word unchanged; fall-through mode still moves a stored word out while no word is shown.
// - Read strobes are ignored while the empty flag is low.
// - Write strobe low at a clock edge stores the word and advances pointer.
// - Write strobe high leaves memory and write pointer unchanged.
// - Write strobes are ignored while the full flag is low.
// - Reset clears both pointers; full, almost-full high; empty, almost-empty low.
// - Half-full output goes low when more than half the locations hold words; in depth mode the pin carries the write-chain pulse instead.
// - First-load, read-chain-in, write-chain-in decode mode and flag timing.
// - Chain inputs connect to the chain outputs of the preceding device.
// - Depth expansion: pulse read-chain output when the last location is read.
// - Depth expansion: pulse write-chain output when the last location is written.
// - Empty pin is empty flag in standard mode, word-ready in fall-through.
// - Full pin is full flag in standard mode, space-ready in fall-through.
// - Almost flags assert within programmed offsets, both reset to 127.
`ifndef FIFO_CTL_MAP_VH
`define FIFO_CTL_MAP_VH

`define OFS_CTRL        8'h00
`define OFS_OFFSET      8'h04
`define OFS_STATUS      8'h08
`define OFS_INT_STAT    8'h0C
`define OFS_INT_MASK    8'h10

`define CTRL_DEPTH_BIT  0
`define OFF_AE_LSB      0
`define OFF_AF_LSB      16
`define OFF_W           12
`define OFFSET_RST      12'h07F

`define STAT_EMPTY_BIT  16
`define STAT_FULL_BIT   17
`define STAT_AE_BIT     18
`define STAT_AF_BIT     19
`define STAT_HF_BIT     20
`define STAT_MODE_LSB   24
`define STAT_DEPTH_BIT  27
`define STAT_WTOK_BIT   28
`define STAT_RTOK_BIT   29

`define IRQ_WR_REJ      0
`define IRQ_RD_REJ      1
`define IRQ_FULL        2
`define IRQ_EMPTY       3
`define IRQ_W           4

`define SYNC_STAGES     2

`endif

// file: src/fifo_store.v
`timescale 1ns/100ps
module fifo_store #(
  parameter DW = 18,
  parameter AW = 12
) (
  input  wire          clk_i,
  input  wire          wr_en_i,
  input  wire [AW-1:0] wr_addr_i,
  input  wire [DW-1:0] wr_data_i,
  input  wire          rd_en_i,
  input  wire [AW-1:0] rd_addr_i,
  output reg  [DW-1:0] rd_data_o
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    if (rd_en_i) begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule

// file: src/gray_sync.v
`timescale 1ns/100ps
module gray_sync #(
  parameter W = 13
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta;
      reg sync;
      always @(posedge clk_i) begin
        if (rst_i) begin
          meta <= 1'b0;
          sync <= 1'b0;
        end else begin
          meta <= d_i[i];
          sync <= meta;
        end
      end
      assign q_o[i] = sync;
    end
  endgenerate

endmodule

// file: verif/fifo_ctl_props.sv
`timescale 1ns/100ps
module fifo_ctl_props #(
  parameter DW = 18
) (
  input wire          CLK_I,
  input wire          RST_I,
  input wire          PSEL_I,
  input wire          PENABLE_I,
  input wire          PREADY_O,
  input wire          PSLVERR_O,
  input wire          MASTER_RESET_N_I,
  input wire          FIRST_LOAD_N_I,
  input wire          WRITE_CHAIN_IN_N_I,
  input wire          WRITE_EN_N_I,
  input wire          READ_EN_N_I,
  input wire [DW-1:0] READ_DATA_BUS_O,
  input wire          EMPTY_FLAG_N_O,
  input wire          FULL_FLAG_N_O,
  input wire          ALMOST_EMPTY_N_O,
  input wire          ALMOST_FULL_N_O,
  input wire          HALF_FULL_N_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  property p_rd_hold;
    (FIRST_LOAD_N_I || !WRITE_CHAIN_IN_N_I) &&
    $past(READ_EN_N_I) && $past(READ_EN_N_I, 2) && $past(READ_EN_N_I, 3) && $past(MASTER_RESET_N_I)
      |-> $stable(READ_DATA_BUS_O);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("word moved without read");
  property p_empty_rd;
    (!EMPTY_FLAG_N_O && MASTER_RESET_N_I) [*3] ##0 !READ_EN_N_I |-> ##2 $stable(READ_DATA_BUS_O);
  endproperty
  a_empty_rd: assert property (p_empty_rd) else $error("read taken while empty");
  property p_full_wr;
    (READ_EN_N_I && MASTER_RESET_N_I) [*4] ##0 (!FULL_FLAG_N_O && !WRITE_EN_N_I) |=> !FULL_FLAG_N_O [*2];
  endproperty
  a_full_wr: assert property (p_full_wr) else $error("write taken while full");
  property p_mreset;
    !MASTER_RESET_N_I |=> !EMPTY_FLAG_N_O && FULL_FLAG_N_O && !ALMOST_EMPTY_N_O && ALMOST_FULL_N_O;
  endproperty
  a_mreset: assert property (p_mreset) else $error("flags wrong under reset");
  property p_half;
    !FIRST_LOAD_N_I && !FULL_FLAG_N_O |-> !HALF_FULL_N_O;
  endproperty
  a_half: assert property (p_half) else $error("full but half flag high");
  property p_full_cause;
    $fell(FULL_FLAG_N_O) |-> !$past(WRITE_EN_N_I) || !$past(WRITE_EN_N_I, 2) || !$past(WRITE_EN_N_I, 3);
  endproperty
  a_full_cause: assert property (p_full_cause) else $error("full without write");
  property p_wait;
    $rose(PENABLE_I) && PSEL_I |-> !PREADY_O ##1 PREADY_O;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer not after one wait");
  property p_ready_cause;
    PREADY_O |-> $past(PSEL_I) && $past(PENABLE_I);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready outside access");
  property p_err;
    PSLVERR_O |-> PREADY_O;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  c_full_wr: cover property (!FULL_FLAG_N_O && !WRITE_EN_N_I);
  c_empty_rd: cover property (!EMPTY_FLAG_N_O && !READ_EN_N_I);
  c_err: cover property (PSLVERR_O);
endmodule
bind fifo_port_ctrl fifo_ctl_props #(.DW(DW)) u_props (
  .CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .MASTER_RESET_N_I(MASTER_RESET_N_I),
  .FIRST_LOAD_N_I(FIRST_LOAD_N_I), .WRITE_CHAIN_IN_N_I(WRITE_CHAIN_IN_N_I),
  .WRITE_EN_N_I(WRITE_EN_N_I), .READ_EN_N_I(READ_EN_N_I), .READ_DATA_BUS_O(READ_DATA_BUS_O),
  .EMPTY_FLAG_N_O(EMPTY_FLAG_N_O), .FULL_FLAG_N_O(FULL_FLAG_N_O), .ALMOST_EMPTY_N_O(ALMOST_EMPTY_N_O),
  .ALMOST_FULL_N_O(ALMOST_FULL_N_O), .HALF_FULL_N_O(HALF_FULL_N_O));

// file: verif/fifo_user_model.sv
`timescale 1ns/100ps
module fifo_user_model #(
  parameter DW = 18
) (
  input  wire           clk_i,
  output logic          wen_n_o,
  output logic [DW-1:0] wdata_o,
  output logic          ren_n_o
);
  initial begin
    wen_n_o = 1'b1;
    ren_n_o = 1'b1;
    wdata_o = '0;
  end
  // Called only after reset is released, one word per strobe
  task put(input logic [DW-1:0] w);
    wen_n_o <= 1'b0;
    wdata_o <= w;
    @(posedge clk_i);
    wen_n_o <= 1'b1;
    wdata_o <= ~w;
    @(posedge clk_i);
  endtask
  task take;
    ren_n_o <= 1'b0;
    @(posedge clk_i);
    ren_n_o <= 1'b1;
    @(posedge clk_i);
  endtask
endmodule

// file: verif/test_dual_clock_sync_fifo_port_control.sv
`timescale 1ns/100ps
module test_dual_clock_sync_fifo_port_control;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        mrst_n = 1'b0;
  logic        fl_n = 1'b0;
  logic        wxi_n = 1'b0;
  logic        rxi_n = 1'b1;
  integer      wxo_cnt = 0;
  integer      rxo_cnt = 0;
  wire         wen_n, ren_n, pready, pslverr, irq;
  wire         empty_n, full_n, ae_n, af_n, half_n, rchain_n;
  wire  [17:0] wdata, rdata;
  wire  [31:0] prdata;
  logic [17:0] q[$];
  logic [17:0] last = 18'h0;
  logic [31:0] r, w;
  logic        e;
  integer      seed = 32'h029d;
  integer      fail_count = 0;
  integer      n_compared = 0;
  integer      i;
  always #10 clk = ~clk;
  // Count chain pulses while the device sits in a depth chain
  always @(posedge clk) begin
    if (fl_n) begin
      wxo_cnt <= wxo_cnt + (half_n ? 0 : 1);
      rxo_cnt <= rxo_cnt + (rchain_n ? 0 : 1);
    end
  end
  fifo_user_model #(.DW(18)) u_user (.clk_i(clk), .wen_n_o(wen_n), .wdata_o(wdata), .ren_n_o(ren_n));
  fifo_port_ctrl #(.DW(18), .AW(4), .DEPTH(16)) DUT (
    .CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .MASTER_RESET_N_I(mrst_n), .WRITE_EN_N_I(wen_n), .WRITE_DATA_BUS_I(wdata), .READ_EN_N_I(ren_n),
    .READ_DATA_BUS_O(rdata), .FIRST_LOAD_N_I(fl_n), .READ_CHAIN_IN_N_I(rxi_n), .WRITE_CHAIN_IN_N_I(wxi_n),
    .EMPTY_FLAG_N_O(empty_n), .FULL_FLAG_N_O(full_n), .ALMOST_EMPTY_N_O(ae_n), .ALMOST_FULL_N_O(af_n),
    .HALF_FULL_N_O(half_n), .READ_CHAIN_OUT_N_O(rchain_n), .IRQ_O(irq));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Flags predicted from the model's word count with offsets of 3
  task flags_chk;
    int n;
    n = q.size();
    chk({26'h0, empty_n, full_n, ae_n, af_n, half_n, rchain_n},
        {26'h0, n != 0, n != 16, n > 3, n < 13, n <= 8, 1'b1});
  endtask
  task tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    mrst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, 8'h04, 32'h0, r, e);
    chk(r, 32'h007F007F);
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk(r, 32'h0);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    apb(1'b1, 8'h04, 32'h00030003, r, e);
    apb(1'b0, 8'h04, 32'h0, r, e);
    chk(r, 32'h00030003);
    for (i = 0; i < 5; i++) begin
      w = $random(seed);
      u_user.put(w[17:0]);
    end
    mrst_n <= 1'b0;
    repeat (2) @(posedge clk);
    flags_chk();
    mrst_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (i = 0; i < 17; i++) begin
      w = $random(seed);
      u_user.put(w[17:0]);
      if (q.size() < 16) q.push_back(w[17:0]);
      repeat (6) @(posedge clk);
      flags_chk();
    end
    for (i = 0; i < 17; i++) begin
      u_user.take();
      repeat (6) @(posedge clk);
      if (q.size() > 0) last = q.pop_front();
      chk({14'h0, rdata}, {14'h0, last});
      flags_chk();
    end
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, 8'h0C, 32'h0, r, e);
    chk(r, 32'h0000000F);
    apb(1'b1, 8'h10, 32'h0000000F, r, e);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 8'h0C, 32'h0000000F, r, e);
    repeat (3) @(posedge clk);
    apb(1'b0, 8'h0C, 32'h0, r, e);
    chk(r, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Fall-through mode with direct-count almost flags
    fl_n <= 1'b0;
    wxi_n <= 1'b1;
    rxi_n <= 1'b0;
    mrst_n <= 1'b0;
    repeat (2) @(posedge clk);
    mrst_n <= 1'b1;
    @(posedge clk);
    w = $random(seed);
    u_user.put(w[17:0]);
    repeat (6) @(posedge clk);
    chk({13'h0, empty_n, rdata}, {13'h0, 1'b1, w[17:0]});
    u_user.take();
    repeat (2) @(posedge clk);
    chk({13'h0, empty_n, rdata}, {13'h0, 1'b0, w[17:0]});
    // Depth chain member: waits for the chain tokens
    fl_n <= 1'b1;
    wxi_n <= 1'b1;
    rxi_n <= 1'b1;
    mrst_n <= 1'b0;
    repeat (2) @(posedge clk);
    mrst_n <= 1'b1;
    @(posedge clk);
    wxi_n <= 1'b0;
    rxi_n <= 1'b0;
    @(posedge clk);
    wxi_n <= 1'b1;
    rxi_n <= 1'b1;
    for (i = 0; i < 17; i++) begin
      w = $random(seed);
      u_user.put(w[17:0]);
      if (i < 16) q.push_back(w[17:0]);
    end
    repeat (6) @(posedge clk);
    chk(wxo_cnt, 32'h1);
    for (i = 0; i < 16; i++) begin
      u_user.take();
      repeat (2) @(posedge clk);
      chk({14'h0, rdata}, {14'h0, q.pop_front()});
    end
    repeat (2) @(posedge clk);
    chk(rxo_cnt, 32'h1);
    chk({31'h0, empty_n}, 32'h0);
    tally_and_finish();
  end
endmodule
